/* verif/asfc_host_model.sv */
// host end of the serial audio bus: free-running bit clock, I2S frame clock, data to the block
// assumes 32 bit clocks per half frame; the word length is taken at each frame start
module asfc_host_model (
  input wire logic [5:0] wl_in,
  input wire logic [23:0] tx_left_in,
  input wire logic [23:0] tx_right_in,
  input wire logic sdo_in,
  input wire logic oe_in,
  output logic bclk_out,
  output logic lrclk_out,
  output logic sdi_out,
  output logic [23:0] rx_left_out,
  output logic [23:0] rx_right_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int wl;
  logic [23:0] word;
  logic [23:0] cap;
  // odd start offset keeps the bus clock edges off the core clock edges, which fall on even ns
  initial begin
    bclk_out = 1'b1;
    lrclk_out = 1'b1;
    sdi_out = 1'b0;
    rx_left_out = 24'h0;
    rx_right_out = 24'h0;
    wl = 24;
    #7;
    forever begin
      for (int h = 0; h < 2; h++) begin
        if (h == 0) wl = wl_in; // length changes only at frame start
        word = (h != 0) ? tx_right_in : tx_left_in;
        cap = 24'h0;
        for (int p = 0; p < 32; p++) begin
          #40 bclk_out = 1'b0;
          if (p == 0) lrclk_out = (h != 0); // low half is left
          // MSB on the second rising edge after the transition
          if (p >= 1 && p <= wl && p <= 24) sdi_out = word[24-p];
          else sdi_out = ~sdi_out; // filler and 32-bit tail carry junk
          #40 bclk_out = 1'b1;
          // a released data line rests at its pull-down
          if (p >= 1 && p <= wl && p <= 24) cap[24-p] = oe_in ? sdo_in : 1'b0;
        end
        if (h == 0) rx_left_out = cap;
        else rx_right_out = cap;
      end
    end
  end
endmodule : asfc_host_model

/* verif/tb_asfc_top.sv */
// testbench for the serial audio format control block: register port and I2S stream
// assumes the host model drives the bus clocks; clock enable is held high except for the one frozen write
module tb_asfc_top;
  import asfc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] HL = 24'hA5C3E1;
  localparam logic [23:0] HR = 24'h1B2D4F;
  logic clk_in, resetn_in, ce, wr, rd, sdo, oe, bclk, lrclk, sdi, dvalid;
  logic [7:0] addr;
  logic [15:0] wdata, rdata;
  logic [23:0] mic_l, mic_r, dac_l, dac_r, hrx_l, hrx_r;
  logic [5:0] wl;
  int miscompares, comparisons;

  asfc_top u_asfc_top (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .bit_clock_in(bclk),
    .frame_clock_in(lrclk), .serial_data_in(sdi), .serial_data_out(sdo), .serial_data_oe_out(oe),
    .digital_microphone_left_in(mic_l), .digital_microphone_right_in(mic_r),
    .dac_left_out(dac_l), .dac_right_out(dac_r), .dac_valid_out(dvalid));
  asfc_host_model u_asfc_host_model (.wl_in(wl), .tx_left_in(HL), .tx_right_in(HR),
    .sdo_in(sdo), .oe_in(oe), .bclk_out(bclk), .lrclk_out(lrclk), .sdi_out(sdi),
    .rx_left_out(hrx_l), .rx_right_out(hrx_r));

  // 250 MHz core clock
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  task automatic chk_reg(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk_reg

  task automatic chk_word(input string n, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk_word

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    chk_reg(n, e, rdata);
  endtask : rd_chk

  // one frame is 64 bit clocks of 80 ns, 1280 core cycles
  task automatic frames(input int n);
    repeat (n * 1280) @(posedge clk_in);
  endtask : frames

  task automatic wait_valid;
    int i;
    i = 0;
    do begin
      @(posedge clk_in);
      #1;
      i++;
    end while (dvalid !== 1'b1 && i < 2000);
    chk_reg("dac_valid", 16'h0001, {15'h0, dvalid});
  endtask : wait_valid

  task automatic check_stream(input logic [23:0] el, er, dl, dr);
    chk_word("host_rx_left", el, hrx_l);
    chk_word("host_rx_right", er, hrx_r);
    chk_word("dac_left", dl, dac_l);
    chk_word("dac_right", dr, dac_r);
  endtask : check_stream

  // counts cycles of one frame in which the data pin is driven
  task automatic oe_count(output int hi);
    hi = 0;
    repeat (1280) begin
      @(posedge clk_in);
      #1;
      if (oe === 1'b1) hi++;
    end
  endtask : oe_count

  task automatic end_sim;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  // a normal run stops well short of this span
  initial begin
    #300us;
    miscompares++;
    end_sim();
  end

  initial begin
    int hi;
    logic [23:0] m;
    resetn_in = 1'b0;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    mic_l = 24'h5E0F96;
    mic_r = 24'hC3A917;
    wl = 6'd24;
    miscompares = 0;
    comparisons = 0;
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd_chk("route_reset", 8'h18, 16'h0050);
    // a low clock enable freezes the register file, so this write is lost
    ce <= 1'b0;
    wr_reg(8'h18, 16'h00A0);
    ce <= 1'b1;
    rd_chk("route_frozen", 8'h18, 16'h0050);
    rd_chk("format_reset", 8'h19, 16'h000A);
    wr_reg(8'h20, 16'hFFFF);
    rd_chk("unmapped", 8'h20, 16'h0000);
    wr_reg(8'h18, 16'hFFFF);
    rd_chk("route_bits", 8'h18, 16'h00F0);
    wr_reg(8'h19, 16'hFFFF);
    rd_chk("format_bits", 8'h19, 16'h3D9F);
    wr_reg(8'h18, 16'h0050);
    wr_reg(8'h19, 16'h000A);
    // default routing, I2S 24-bit in both directions
    frames(3);
    wait_valid();
    check_stream(mic_l, mic_r, HL, HR);
    // status: frame start seen, 32 bit-clock rising edges in each half frame
    rd_chk("status", 8'h1F, 16'h8020);
    // normal mode drives the pin in every cycle of the frame
    oe_count(hi);
    chk_reg("oe_normal", 16'h0500, hi[15:0]);
    // every source swapped
    wr_reg(8'h18, 16'h00A0);
    frames(3);
    check_stream(mic_r, mic_l, HR, HL);
    wr_reg(8'h18, 16'h0050);
    // 16, 20 and 32 bit words; short words keep the top bits only
    for (int c = 0; c < 4; c++) begin
      if (c == 2) continue;
      wl <= (c == 0) ? 6'd16 : (c == 1) ? 6'd20 : 6'd32;
      m = (c == 0) ? 24'hFFFF00 : (c == 1) ? 24'hFFFFF0 : 24'hFFFFFF;
      wr_reg(8'h19, {12'h000, c[1:0], 2'b10});
      frames(3);
      check_stream(mic_l & m, mic_r & m, HL & m, HR & m);
    end
    wl <= 6'd24;
    // tri-state overrides the normal drive of the data pin
    wr_reg(8'h19, 16'h010A);
    repeat (2) @(posedge clk_in);
    oe_count(hi);
    chk_reg("oe_hiz", 16'h0000, hi[15:0]);
    // slot 0 both ways: same words, pin floats for the 8 idle bit clocks of each half (2 x 24 x 20 driven)
    wr_reg(8'h19, 16'h280A);
    frames(3);
    check_stream(mic_l, mic_r, HL, HR);
    oe_count(hi);
    chk_reg("oe_slot", 16'h03C0, hi[15:0]);
    end_sim();
  end
endmodule : tb_asfc_top

/* verilog/asfc_pkg.sv */
// package for the serial audio format control block: register map, field positions, reset values
// assumes a single 250 MHz core clock and an outside bit clock and frame clock
package asfc_pkg;
  // register offsets, reset values and write masks
  localparam logic [7:0] ASFC_ROUTE_OFS = 8'h18;
  localparam logic [7:0] ASFC_FMT_OFS = 8'h19;
  localparam logic [7:0] ASFC_STAT_OFS = 8'h1F;
  localparam logic [15:0] ASFC_ROUTE_RST = 16'h0050;
  localparam logic [15:0] ASFC_FMT_RST = 16'h000A;
  localparam logic [15:0] ASFC_ROUTE_MASK = 16'h00F0;
  localparam logic [15:0] ASFC_FMT_MASK = 16'h3D9F;
  // routing register fields
  localparam int ASFC_TXL_POS = 7;
  localparam int ASFC_TXR_POS = 6;
  localparam int ASFC_RXL_POS = 5;
  localparam int ASFC_RXR_POS = 4;
  // format register fields
  localparam int ASFC_RXTDM_POS = 13;
  localparam int ASFC_RXSEL_POS = 12;
  localparam int ASFC_TXTDM_POS = 11;
  localparam int ASFC_TXSEL_POS = 10;
  localparam int ASFC_HIZ_POS = 8;
  localparam int ASFC_BINV_POS = 7;
  localparam int ASFC_FINV_POS = 4;
  localparam int ASFC_WL_POS = 2;
  localparam int ASFC_FMT_POS = 0;
  // status register fields
  localparam int ASFC_LOCK_POS = 15;
  // frame formats
  localparam logic [1:0] ASFC_FMT_RJ = 2'h0;
  localparam logic [1:0] ASFC_FMT_LJ = 2'h1;
  localparam logic [1:0] ASFC_FMT_I2S = 2'h2;
  localparam logic [1:0] ASFC_FMT_DSP = 2'h3;
  // sample width of the converter core; wider words carry undriven tail bits
  localparam int ASFC_DATA_W = 24;
  localparam int ASFC_CNT_W = 11;

  // word length code to bit count
  function automatic int asfc_wl_bits(input logic [1:0] code);
    case (code)
      2'h0: return 16;
      2'h1: return 20;
      2'h2: return 24;
      default: return 32;
    endcase
  endfunction : asfc_wl_bits
endpackage : asfc_pkg

/* verilog/asfc_sync.sv */
// two-flop synchroniser for the serial bus pins
// assumes inputs are asynchronous to clk_in; the first stage feeds only the second
module asfc_sync #(
  parameter int W = 3
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } asfc_sync_t;
  asfc_sync_t r_reg;
  asfc_sync_t r_next;

  // shift one stage per enabled cycle
  always_comb begin
    r_next = r_reg;
    if (ce_in) begin
      r_next.meta = d_in;
      r_next.sync = r_reg.meta;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q_out = r_reg.sync;
endmodule : asfc_sync

/* verilog/asfc_top.sv */
// serial audio format control: register port, frame tracking, transmit and receive word paths
// assumes slave clocks from outside; microphone words and register port are on clk_in
module asfc_top (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  input wire logic bit_clock_in,
  input wire logic frame_clock_in,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe_out,
  input wire logic [asfc_pkg::ASFC_DATA_W-1:0] digital_microphone_left_in,
  input wire logic [asfc_pkg::ASFC_DATA_W-1:0] digital_microphone_right_in,
  output logic [asfc_pkg::ASFC_DATA_W-1:0] dac_left_out,
  output logic [asfc_pkg::ASFC_DATA_W-1:0] dac_right_out,
  output logic dac_valid_out
);
  import asfc_pkg::*;

  typedef struct packed {
    logic [15:0] s0;
    logic [15:0] s1;
    logic [15:0] a1;
    logic bclk_prev;
    logic frame_clock_short;
    logic [ASFC_CNT_W-1:0] cnt;
    logic [ASFC_CNT_W-1:0] half;
    logic locked;
    logic [ASFC_DATA_W-1:0] txl_w;
    logic [ASFC_DATA_W-1:0] txr_w;
    logic [ASFC_DATA_W-1:0] acc;
    logic [ASFC_DATA_W-1:0] rxl_w;
    logic [ASFC_DATA_W-1:0] rxr_w;
    logic [ASFC_DATA_W-1:0] dac_l;
    logic [ASFC_DATA_W-1:0] dac_r;
    logic dac_v;
    logic sdo;
    logic drive;
    logic oe;
    logic [15:0] rdata;
  } asfc_state_t;

  asfc_state_t r_reg;
  asfc_state_t r_next;
  logic [2:0] pins_sync;
  logic bclk_eff;
  logic rise;
  logic fall;
  logic fstart;
  logic cnt_clr;
  logic left_now;
  logic [7:0] tx_dec;
  logic [7:0] rx_dec;

  // pin synchroniser: bit clock, frame clock and serial input
  asfc_sync #(.W(3)) u_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .d_in({bit_clock_in, frame_clock_in, serial_data_in}),
    .q_out(pins_sync)
  );

  // left phase of the frame clock for a given config; DSP has no phases
  function automatic logic is_left(input logic frame_clock_short, input logic [15:0] c1);
    logic lvl;
    lvl = frame_clock_short ^ (c1[ASFC_FINV_POS] & (c1[ASFC_FMT_POS+:2] != ASFC_FMT_DSP));
    return (c1[ASFC_FMT_POS+:2] == ASFC_FMT_I2S) ? ~lvl : lvl;
  endfunction : is_left

  // position p (rising edges since frame clock transition) to {hit, right, bit index}
  function automatic logic [7:0] slot_decode(input logic [ASFC_CNT_W:0] p, input logic [15:0] c1,
                                            input logic [ASFC_CNT_W-1:0] half, input logic tdm,
                                            input logic sel, input logic left);
    int wl;
    int nch;
    int base;
    int j;
    logic dsp;
    logic [7:0] res;
    wl = asfc_wl_bits(c1[ASFC_WL_POS+:2]);
    dsp = (c1[ASFC_FMT_POS+:2] == ASFC_FMT_DSP);
    nch = dsp ? 2 : 1;
    res = 8'h00;
    case (c1[ASFC_FMT_POS+:2])
      ASFC_FMT_LJ: base = 1;
      ASFC_FMT_I2S: base = 2;
      ASFC_FMT_DSP: base = c1[ASFC_FINV_POS] ? 1 : 2;
      default: base = int'(half) - (tdm ? 2 : 1) * nch * wl + 1;
    endcase
    j = int'(p) - base - ((tdm && sel) ? nch * wl : 0);
    if (j >= 0 && j < nch * wl) begin
      res[7] = 1'b1;
      res[6] = dsp ? (j >= wl) : ~left;
      res[5:0] = 6'((dsp && j >= wl) ? j - wl : j);
    end
    return res;
  endfunction : slot_decode

  // edges of the effective bit clock; polarity comes from the active config
  assign bclk_eff = pins_sync[2] ^ r_reg.a1[ASFC_BINV_POS];
  assign rise = bclk_eff & ~r_reg.bclk_prev;
  assign fall = ~bclk_eff & r_reg.bclk_prev;
  assign left_now = is_left(pins_sync[1], r_reg.a1);
  // frame start: DSP on frame clock rise, other formats on entry to the left phase
  assign fstart = fall & ((r_reg.a1[ASFC_FMT_POS+:2] == ASFC_FMT_DSP) ? (pins_sync[1] & ~r_reg.frame_clock_short)
                                                                     : ((pins_sync[1] != r_reg.frame_clock_short) & left_now));
  assign cnt_clr = fall & ((r_reg.a1[ASFC_FMT_POS+:2] == ASFC_FMT_DSP) ? fstart : (pins_sync[1] != r_reg.frame_clock_short));
  // transmit looks at the coming edge with the config that will then be active
  assign tx_dec = slot_decode(cnt_clr ? 12'h001 : {1'b0, r_reg.cnt} + 12'h001, fstart ? r_reg.s1 : r_reg.a1,
                              cnt_clr ? r_reg.cnt : r_reg.half,
                              (fstart ? r_reg.s1[ASFC_TXTDM_POS] : r_reg.a1[ASFC_TXTDM_POS]),
                              (fstart ? r_reg.s1[ASFC_TXSEL_POS] : r_reg.a1[ASFC_TXSEL_POS]),
                              is_left(pins_sync[1], fstart ? r_reg.s1 : r_reg.a1));
  assign rx_dec = slot_decode({1'b0, r_reg.cnt} + 12'h001, r_reg.a1, r_reg.half, r_reg.a1[ASFC_RXTDM_POS],
                              r_reg.a1[ASFC_RXSEL_POS], is_left(r_reg.frame_clock_short, r_reg.a1));

  // next-state logic for the whole block
  always_comb begin
    logic [ASFC_DATA_W-1:0] txl;
    logic [ASFC_DATA_W-1:0] txr;
    logic [ASFC_DATA_W-1:0] accv;
    logic [5:0] kb;
    logic [5:0] wlm1;
    r_next = r_reg;
    txl = r_reg.txl_w;
    txr = r_reg.txr_w;
    accv = r_reg.acc;
    kb = 6'h00;
    wlm1 = 6'(asfc_wl_bits(r_reg.a1[ASFC_WL_POS+:2]) - 1);
    if (ce_in) begin
      r_next.dac_v = 1'b0;
      r_next.bclk_prev = bclk_eff;
      // register port: writes store the shadow copy, reads answer next cycle only
      r_next.rdata = 16'h0000;
      if (wr_in && addr_in == ASFC_ROUTE_OFS) begin
        r_next.s0 = wdata_in & ASFC_ROUTE_MASK;
      end
      if (wr_in && addr_in == ASFC_FMT_OFS) begin
        r_next.s1 = wdata_in & ASFC_FMT_MASK;
      end
      if (rd_in) begin
        case (addr_in)
          ASFC_ROUTE_OFS: r_next.rdata = r_reg.s0;
          ASFC_FMT_OFS: r_next.rdata = r_reg.s1;
          ASFC_STAT_OFS: r_next.rdata = {r_reg.locked, 4'h0, r_reg.half};
          default: r_next.rdata = 16'h0000;
        endcase
      end
      // frame start: adopt new settings, pick up mic words, hand last frame to the DAC
      if (fstart) begin
        r_next.a1 = r_reg.s1;
        r_next.locked = 1'b1;
        txl = r_reg.s0[ASFC_TXL_POS] ? digital_microphone_right_in : digital_microphone_left_in;
        txr = r_reg.s0[ASFC_TXR_POS] ? digital_microphone_right_in : digital_microphone_left_in;
        r_next.txl_w = txl;
        r_next.txr_w = txr;
        r_next.dac_l = r_reg.s0[ASFC_RXL_POS] ? r_reg.rxr_w : r_reg.rxl_w;
        r_next.dac_r = r_reg.s0[ASFC_RXR_POS] ? r_reg.rxr_w : r_reg.rxl_w;
        r_next.dac_v = 1'b1;
      end
      // falling edge: track frame clock, set up the data bit for the next rising edge
      if (fall) begin
        r_next.frame_clock_short = pins_sync[1];
        if (cnt_clr) begin
          r_next.half = r_reg.cnt;
          r_next.cnt = '0;
        end
        kb = tx_dec[5:0];
        r_next.drive = tx_dec[7] && kb < 6'(ASFC_DATA_W);
        r_next.sdo = r_next.drive ? (tx_dec[6] ? txr[5'(ASFC_DATA_W - 1) - 5'(kb)]
                                               : txl[5'(ASFC_DATA_W - 1) - 5'(kb)]) : 1'b0;
        // normal mode drives idle bits low; slot mode floats outside the word
        if (!(fstart ? r_reg.s1[ASFC_TXTDM_POS] : r_reg.a1[ASFC_TXTDM_POS])) begin
          r_next.drive = ~(tx_dec[7] && kb >= 6'(ASFC_DATA_W));
        end
      end
      // rising edge: count and sample the serial input into the accumulator
      if (rise) begin
        if (r_reg.cnt != '1) begin
          r_next.cnt = r_reg.cnt + 11'h001;
        end
        if (rx_dec[7]) begin
          kb = rx_dec[5:0];
          if (kb == 6'h00) begin
            accv = '0;
          end
          if (kb < 6'(ASFC_DATA_W)) begin
            accv[5'(ASFC_DATA_W - 1) - 5'(kb)] = pins_sync[0];
          end
          r_next.acc = accv;
          // a 32-bit word is complete at its last kept bit; its tail may spill past the next frame clock edge
          if (kb == wlm1 || kb == 6'(ASFC_DATA_W - 1)) begin
            if (rx_dec[6]) begin
              r_next.rxr_w = accv;
            end else begin
              r_next.rxl_w = accv;
            end
          end
        end
      end
      // tri-state acts at once and overrides every other enable
      r_next.oe = r_next.drive & ~r_reg.s1[ASFC_HIZ_POS];
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r_reg <= '0;
      r_reg.s0 <= ASFC_ROUTE_RST;
      r_reg.s1 <= ASFC_FMT_RST;
      r_reg.a1 <= ASFC_FMT_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rdata_out = r_reg.rdata;
  assign serial_data_out = r_reg.sdo;
  assign serial_data_oe_out = r_reg.oe;
  assign dac_left_out = r_reg.dac_l;
  assign dac_right_out = r_reg.dac_r;
  assign dac_valid_out = r_reg.dac_v;

  // checks
  property p_hiz;
    @(posedge clk_in) disable iff (!resetn_in)
      (ce_in && r_reg.s1[ASFC_HIZ_POS]) |=> !serial_data_oe_out;
  endproperty
  a_hiz: assert property (p_hiz) else $error("data pin driven while tri-state set");

  property p_txl_src;
    @(posedge clk_in) disable iff (!resetn_in)
      (ce_in && fstart && !r_reg.s0[ASFC_TXL_POS]) |=> r_reg.txl_w == $past(digital_microphone_left_in);
  endproperty
  a_txl_src: assert property (p_txl_src) else $error("left transmit word has wrong source");

  property p_txr_src;
    @(posedge clk_in) disable iff (!resetn_in)
      (ce_in && fstart && r_reg.s0[ASFC_TXR_POS]) |=> r_reg.txr_w == $past(digital_microphone_right_in);
  endproperty
  a_txr_src: assert property (p_txr_src) else $error("right transmit word has wrong source");

  property p_dacl_src;
    @(posedge clk_in) disable iff (!resetn_in)
      (ce_in && fstart && r_reg.s0[ASFC_RXL_POS]) |=> dac_valid_out && dac_left_out == $past(r_reg.rxr_w);
  endproperty
  a_dacl_src: assert property (p_dacl_src) else $error("left dac word has wrong source");

  property p_dacr_src;
    @(posedge clk_in) disable iff (!resetn_in)
      (ce_in && fstart && !r_reg.s0[ASFC_RXR_POS]) |=> dac_right_out == $past(r_reg.rxl_w);
  endproperty
  a_dacr_src: assert property (p_dacr_src) else $error("right dac word has wrong source");

  property p_cfg_hold;
    @(posedge clk_in) disable iff (!resetn_in)
      !fstart |=> $stable(r_reg.a1);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("active format changed outside frame start");

  property p_slot_float;
    @(posedge clk_in) disable iff (!resetn_in)
      (ce_in && fall && !fstart && r_reg.a1[ASFC_TXTDM_POS] && !tx_dec[7]) |=> ##1 !serial_data_oe_out;
  endproperty
  a_slot_float: assert property (p_slot_float) else $error("data pin driven outside own slot");

  property p_tail_float;
    @(posedge clk_in) disable iff (!resetn_in)
      (ce_in && fall && tx_dec[7] && tx_dec[5:0] >= 6'(ASFC_DATA_W)) |=> ##1 !serial_data_oe_out;
  endproperty
  a_tail_float: assert property (p_tail_float) else $error("32-bit tail bits driven");

  c_frame: cover property (@(posedge clk_in) disable iff (!resetn_in) fstart ##[1:200] fstart);
  c_dac: cover property (@(posedge clk_in) disable iff (!resetn_in) dac_valid_out);
  c_slot: cover property (@(posedge clk_in) disable iff (!resetn_in)
    r_reg.a1[ASFC_TXTDM_POS] && serial_data_oe_out);
endmodule : asfc_top
